// >>> rtl/ich_defines.svh
// Constants for the invalid-command handler of the disk controller command interpreter.
`ifndef ICH_DEFINES_SVH
`define ICH_DEFINES_SVH

// ============================================================
// Main status register bit positions
`define ICH_MSR_DIO_BIT 6
`define ICH_MSR_RQM_BIT 7

// ============================================================
// Result codes and command decode
`define ICH_ST0_INVALID 8'h80
`define ICH_OPC_MASK 8'h1f
`define ICH_DEF_OPC_MAP 32'h0000_0000

// ============================================================
// Timing
`define ICH_POLL_PERIOD_NS 1024
`define ICH_CLK_PERIOD_NS 4
`define ICH_POLL_CYCLES (`ICH_POLL_PERIOD_NS / `ICH_CLK_PERIOD_NS)

`endif

// >>> rtl/ich_pkg.sv
// Types shared by the invalid-command handler files.
package ich_pkg;

    // ============================================================
    // Interpreter phases.
    typedef enum logic [1:0] {
        ICH_IDLE = 2'b00,
        ICH_EXEC = 2'b01,
        ICH_RESULT = 2'b10
    } ich_phase_t;

    // Host-side write strobe with its byte.
    typedef struct packed {
        logic wr;
        logic [7:0] data;
    } ich_wr_t;

endpackage

// >>> rtl/ich_poll_timer.sv
// Periodic drive poll tick generator that can be held off.
`timescale 1ns/1ps
`default_nettype none
`include "ich_defines.svh"

module ich_poll_timer import ich_pkg::*; #(
    parameter int unsigned PERIOD = `ICH_POLL_CYCLES
) (
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Control.
    input wire logic run_in,
    // Tick.
    output logic tick_out
);

    localparam int unsigned CW = $clog2(PERIOD + 1);

    logic [CW-1:0] cnt_q;

    // ============================================================
    // Counter; it restarts from zero when released so the first poll after a hold is a full period.
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_q <= '0;
            tick_out <= 1'b0;
        end else if (!run_in) begin
            cnt_q <= '0;
            tick_out <= 1'b0;
        end else if (cnt_q == CW'(PERIOD - 1)) begin
            cnt_q <= '0;
            tick_out <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 1'b1;
            tick_out <= 1'b0;
        end
    end

endmodule // ich_poll_timer
`default_nettype wire

// >>> rtl/ich_handler.sv
// Command interpreter slice that rejects undefined opcodes and reports them.
// Contract
// (RL1) Undefined opcode ends command, no execution phase.
// (RL2) No interrupt raised for a rejected opcode.
// (RL3) Status bits six and seven set together.
// (RL4) First result status byte reads hex 80.
// (RL5) Drive polling suspended while result unread.
// (RL6) Host may park controller using undefined opcode.
// (RL7) Reading the byte clears result, resumes polling.
`timescale 1ns/1ps
`default_nettype none
`include "ich_defines.svh"

// This slice sits between the host port decode and the execution engine. It owns the
// interpreter phase, the two host-visible status bits and the first result byte for a
// rejected opcode. A rejected opcode is a cheap way to park the controller: nothing runs,
// nothing is polled and no interrupt is raised until the host reads the byte back.
// Limitation: only the low five opcode bits are decoded, so commands that differ only in
// their upper flag bits cannot be told apart here.

module ich_handler import ich_pkg::*; #(
    parameter logic [31:0] DEF_OPC_MAP = `ICH_DEF_OPC_MAP,
    parameter int unsigned POLL_CYCLES = `ICH_POLL_CYCLES
) (
    // Clock and reset.
    input wire logic mclk_in,
    input wire logic rst_n_in,
    // Host port: command write and status/result reads.
    input wire ich_wr_t cmd_in,
    input wire logic res_rd_in,
    // Configuration and completion from the rest of the controller.
    input wire logic poll_en_in,
    input wire logic exec_done_in,
    // Main status and result.
    output logic [7:0] msr_out,
    output logic [7:0] result_out,
    // Drive side and interrupt.
    output logic exec_start_out,
    output logic poll_tick_out,
    output logic int_out
);

    // Interpreter phase and the flag that marks the pending result as a rejection.
    ich_phase_t phase_q;
    logic invalid_q;
    // Poll enable as seen by the timer, and the raw tick that comes back from it.
    logic poll_run_q;
    logic poll_tick;

    // Opcode lookup: a set bit in the map marks a defined command.
    // The mask is applied before the cast, so the index never grows past the map.
    function automatic logic opc_defined(input logic [7:0] b);
        logic [4:0] idx;
        idx = 5'(b & `ICH_OPC_MASK);
        return DEF_OPC_MAP[idx];
    endfunction

    // ============================================================
    // Phase sequencing. An undefined opcode jumps straight to the result phase.
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase_q <= ICH_IDLE;
            invalid_q <= 1'b0;
        end else begin
            case (phase_q)
                ICH_IDLE: begin
                    // Only idle takes a byte; writes in any other phase are dropped silently,
                    // so the host must watch the ready and direction bits before it writes.
                    if (cmd_in.wr) begin
                        if (opc_defined(cmd_in.data)) begin
                            phase_q <= ICH_EXEC;
                        end else begin
                            phase_q <= ICH_RESULT; // RL1
                            invalid_q <= 1'b1;
                        end
                    end
                end
                ICH_EXEC: begin
                    // A defined command reports through the same result phase when it ends.
                    if (exec_done_in) begin
                        phase_q <= ICH_RESULT;
                    end
                end
                ICH_RESULT: begin
                    // Reading the byte ends the result phase.
                    if (res_rd_in) begin
                        phase_q <= ICH_IDLE; // RL7
                        invalid_q <= 1'b0;
                    end
                end
                default: begin
                    // An unused code falls back to idle so a glitch cannot lock the host out.
                    phase_q <= ICH_IDLE;
                    invalid_q <= 1'b0;
                end
            endcase
        end
    end

    // ============================================================
    // Host-visible status, registered so the outputs are glitch free.
    // The register costs one cycle of status latency, which a polling host absorbs.
    // Bits other than six and seven are not kept by this slice and read as zero.
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            msr_out <= 8'h00;
            result_out <= 8'h00;
        end else begin
            msr_out <= 8'h00;
            msr_out[`ICH_MSR_RQM_BIT] <= (phase_q != ICH_EXEC);
            msr_out[`ICH_MSR_DIO_BIT] <= (phase_q == ICH_RESULT); // RL3
            result_out <= (phase_q == ICH_RESULT && invalid_q) ? `ICH_ST0_INVALID : 8'h00; // RL4
        end
    end

    // ============================================================
    // Drive-side effects. Only defined commands start execution; rejections never interrupt.
    // The interrupt of a defined command belongs to the execution engine, not to this slice.
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            exec_start_out <= 1'b0;
            int_out <= 1'b0;
        end else begin
            exec_start_out <= (phase_q == ICH_IDLE) && cmd_in.wr && opc_defined(cmd_in.data); // RL1
            int_out <= 1'b0; // RL2
        end
    end

    // ============================================================
    // Polling runs only in idle, so a parked controller leaves the drives alone.
    // The run flag lags the phase by a cycle and the timer adds one more, so the tick is
    // also gated with the present phase; otherwise a late tick could follow a rejection.
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            poll_run_q <= 1'b0;
            poll_tick_out <= 1'b0;
        end else begin
            poll_run_q <= poll_en_in && (phase_q == ICH_IDLE) && !invalid_q; // RL5
            poll_tick_out <= poll_tick && (phase_q == ICH_IDLE) && !invalid_q; // RL5
        end
    end

    // Poll timer; it restarts on every release, so polls stay evenly spaced after a park.
    ich_poll_timer #(
        .PERIOD(POLL_CYCLES)
    ) u_poll (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n_in),
        .run_in(poll_run_q),
        .tick_out(poll_tick)
    );

    // ============================================================
    // Checks. Each one watches registered outputs or state, so an expectation sits one edge after
    // the phase that causes it.
    sequence s_reject;
        phase_q == ICH_IDLE && cmd_in.wr && !opc_defined(cmd_in.data);
    endsequence

    sequence s_report;
        msr_out[7:6] == 2'b11 && result_out == 8'h80;
    endsequence

    sequence s_accept;
        phase_q == ICH_IDLE && cmd_in.wr && opc_defined(cmd_in.data);
    endsequence

    sequence s_start;
        exec_start_out && phase_q == ICH_EXEC;
    endsequence

    // Rejection path, plus defined-opcode start and busy-write drop.
    AST_REJECT_REPORT: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RL3
        s_reject ##1 !res_rd_in |-> ##1 s_report)
        else $error("Rejected opcode not reported in status.");

    AST_REJECT_NO_EXEC: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RL1
        s_reject |=> !exec_start_out && phase_q == ICH_RESULT)
        else $error("Rejected opcode started execution.");

    AST_NO_INT: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RL2
        s_reject |=> !int_out [*4])
        else $error("Interrupt raised for rejected opcode.");

    AST_ST0_CODE: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RL4
        invalid_q && phase_q == ICH_RESULT |=> result_out == 8'h80)
        else $error("Invalid-command code wrong.");

    AST_ACCEPT_STARTS: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RL1
        s_accept |=> s_start)
        else $error("Defined opcode did not start execution.");

    AST_BUSY_WR_DROPPED: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RL1
        phase_q == ICH_RESULT && cmd_in.wr && !res_rd_in
        |=> phase_q == ICH_RESULT && !exec_start_out)
        else $error("Write taken outside idle.");

    // Recovery, polling and parking.
    AST_NO_POLL: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RL5
        invalid_q |=> !poll_tick_out)
        else $error("Drives polled while rejection unread.");

    AST_POLL_IDLE_ONLY: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RL5
        poll_tick_out |-> $past(phase_q) == ICH_IDLE && !$past(invalid_q))
        else $error("Drive poll outside idle.");

    AST_CLEAR_ON_READ: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RL7
        phase_q == ICH_RESULT && res_rd_in |=> phase_q == ICH_IDLE ##1 msr_out[6] == 1'b0)
        else $error("Result phase not cleared after read.");

    AST_IDLE_STATUS: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RL7
        phase_q == ICH_IDLE |=> msr_out == 8'h80 && result_out == 8'h00)
        else $error("Idle status wrong.");

    AST_POLL_RESUME: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RL7
        $fell(invalid_q) && poll_en_in && phase_q == ICH_IDLE |=> poll_run_q)
        else $error("Polling did not resume.");

    AST_PARK_HOLDS: assert property (@(posedge mclk_in) disable iff (!rst_n_in) // RL6
        invalid_q && !res_rd_in |=> invalid_q && phase_q == ICH_RESULT)
        else $error("Parked state left without a read.");

endmodule // ich_handler
`default_nettype wire

// >>> bench/ich_host_model.sv
// Host processor model that writes command bytes and reads result bytes.
`timescale 1ns/1ps
`default_nettype none
module ich_host_model import ich_pkg::*; (
    // Clock.
    input wire logic mclk_in,
    // Host port.
    output var ich_wr_t cmd_out,
    output var logic res_rd_out
);
    // ============================================================
    // Host accesses, changed on the falling edge only.
    initial begin
        cmd_out = '{wr: 1'b0, data: 8'h00};
        res_rd_out = 1'b0;
    end
    // The byte is inverted after the strobe so a stale value never looks valid.
    task automatic put_cmd(input logic [7:0] b);
        @(negedge mclk_in);
        cmd_out = '{wr: 1'b1, data: b};
        @(negedge mclk_in);
        cmd_out = '{wr: 1'b0, data: ~b};
    endtask
    // Parking before the read keeps the controller in standby.
    task automatic get_result(input int unsigned park);
        repeat (park) @(negedge mclk_in);
        res_rd_out = 1'b1;
        @(negedge mclk_in);
        res_rd_out = 1'b0;
    endtask
endmodule // ich_host_model
`default_nettype wire

// >>> bench/tb.sv
// Self-checking testbench for the invalid-command handler.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ich_pkg::*;
    localparam int unsigned POLL = 4;
    logic mclk_in, rst_n_in, poll_en_in, exec_done_in, res_rd, start, tick, irq;
    ich_wr_t cmd;
    logic [7:0] msr, result, op;
    int bad_count = 0, checked = 0, ticks = 0, starts = 0, ints = 0;
    logic [31:0] seed = 32'h7978;
    // ============================================================
    // Design and host model.
    ich_handler #(.DEF_OPC_MAP(32'h0000_0003), .POLL_CYCLES(POLL)) ich_handler_inst (
        .mclk_in(mclk_in), .rst_n_in(rst_n_in), .cmd_in(cmd), .res_rd_in(res_rd),
        .poll_en_in(poll_en_in), .exec_done_in(exec_done_in), .msr_out(msr),
        .result_out(result), .exec_start_out(start), .poll_tick_out(tick), .int_out(irq));
    ich_host_model ich_host_model_inst (.mclk_in(mclk_in), .cmd_out(cmd), .res_rd_out(res_rd));
    // Free-running clock of 4 ns.
    initial begin
        mclk_in = 1'b0;
        forever #2 mclk_in = ~mclk_in;
    end
    // Event counters; case equality keeps unknowns out of the tick and start counts, while an unknown interrupt is counted.
    always @(posedge mclk_in) begin
        ticks += (tick === 1'b1);
        starts += (start === 1'b1);
        ints += (irq !== 1'b0);
    end
    // ============================================================
    // Helpers.
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Opcodes 0 and 1 are the only defined ones here, so push others above them.
    function automatic logic [7:0] undef(input logic [7:0] b);
        return (b[4:1] == 4'h0) ? (b | 8'h10) : b;
    endfunction
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic final_report;
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // The whole run needs at most about 1500 cycles; this bound is well past it.
    initial begin
        #40000;
        bad_count++;
        final_report();
    end
    // ============================================================
    // Main sequence.
    initial begin
        rst_n_in = 1'b0;
        poll_en_in = 1'b1;
        exec_done_in = 1'b0;
        repeat (4) @(negedge mclk_in);
        rst_n_in = 1'b1;
        repeat (2) @(negedge mclk_in);
        check("msr_idle", 8'h80, msr);
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            op = (i == 0) ? 8'h02 : (i == 1) ? 8'hff : undef(seed[7:0]);
            // Polling is switched off now and then, so resumption must follow the enable.
            poll_en_in = seed[25] | (i < 2);
            starts = 0;
            ints = 0;
            ich_host_model_inst.put_cmd(op);
            repeat (2) @(negedge mclk_in);
            check("msr_reject", 8'hc0, msr);
            check("result", 8'h80, result);
            ticks = 0;
            // A defined opcode during the result phase must be ignored.
            ich_host_model_inst.put_cmd({seed[15:13], 4'h0, seed[16]});
            ich_host_model_inst.get_result(1 + seed[12:8]);
            check("ticks_parked", 8'h00, 8'(ticks));
            check("starts", 8'h00, 8'(starts));
            check("ints", 8'h00, 8'(ints));
            repeat (2) @(negedge mclk_in);
            check("msr_back", 8'h80, msr);
            check("result_clr", 8'h00, result);
            ticks = 0;
            repeat (2 * POLL + 4) @(negedge mclk_in);
            check("ticks_resume", {7'h00, poll_en_in}, (ticks > 0) ? 8'h01 : 8'h00);
            // A defined opcode starts execution, which an undefined one never does.
            starts = 0;
            ich_host_model_inst.put_cmd({seed[23:21], 4'h0, seed[20]});
            repeat (2) @(negedge mclk_in);
            check("starts_def", 8'h01, 8'(starts));
            exec_done_in = 1'b1;
            @(negedge mclk_in);
            exec_done_in = 1'b0;
            // A defined command also ends in a result phase, whose byte is not the reject code.
            repeat (2) @(negedge mclk_in);
            check("msr_exec_res", 8'hc0, msr);
            check("result_def", 8'h00, result);
            ich_host_model_inst.get_result(0);
            repeat (2) @(negedge mclk_in);
            check("msr_after_exec", 8'h80, msr);
        end
        // A reset in the middle of a parked result phase must drop it at once.
        ich_host_model_inst.put_cmd(8'h1f);
        repeat (2) @(negedge mclk_in);
        check("msr_parked", 8'hc0, msr);
        rst_n_in = 1'b0;
        @(negedge mclk_in);
        check("msr_in_reset", 8'h00, msr);
        check("result_in_reset", 8'h00, result);
        rst_n_in = 1'b1;
        repeat (2) @(negedge mclk_in);
        check("msr_after_reset", 8'h80, msr);
        final_report();
    end
endmodule // tb
`default_nettype wire
